// ==== rtl/mac_phy_interface_clocking.v ====
// phy interface selection, clock sourcing and mii signalling of the mac
`timescale 1ns/100ps
`include "mac_phy_map.vh"
module mac_phy_interface_clocking
(
  input  wire        clk,
  input  wire        rst,
  input  wire [1:0]  phy_if_select_pins,
  input  wire [2:0]  refDivSetting,
  input  wire        halfDuplex,
  input  wire [1:0]  linkSpeed,
  input  wire        mii_transmit_clock_in,
  input  wire        mii_receive_clock_in,
  input  wire        txValid,
  input  wire [7:0]  txByte,
  input  wire        txLast,
  input  wire        txUnderflow,
  output wire        txReady,
  output reg  [3:0]  transmit_nibble,
  output reg         transmit_enable_out,
  output reg  [7:0]  gmiiTxData,
  output reg         gmiiTxEnable,
  output reg  [3:0]  rgmiiTxData,
  output reg         gigabit_transmit_clock_out,
  output reg         rgmiiRefClock,
  input  wire [3:0]  receive_nibble,
  input  wire        receive_valid_in,
  input  wire        receive_error_in,
  input  wire [3:0]  rgmiiRxData,
  output reg  [7:0]  rxByte,
  output reg         rxByteValid,
  output reg         rxError,
  output reg  [1:0]  rgmiiRxSpeed,
  input  wire        collision_in,
  input  wire        carrier_sense_in,
  output reg         collisionSeen,
  output reg         carrierSeen,
  output reg  [1:0]  activeIf,
  input  wire [7:0]  management_clock_divider,
  input  wire        mgmtStart,
  input  wire        mgmtRead,
  input  wire [4:0]  mgmtPhyAddr,
  input  wire [4:0]  mgmtRegAddr,
  input  wire [15:0] mgmtWrData,
  output wire        mgmtBusy,
  output wire [15:0] mgmtRdData,
  output wire        management_clock_out,
  output wire        mgmtDataOut,
  output wire        mgmtDataOe,
  input  wire        mgmtDataIn
);
  // ==========================================
  // interface select caught once after reset
  reg  [1:0]  settle_r;
  reg         selDone_r;
  always @(posedge clk)
  begin
    if (rst)
    begin
      settle_r  <= 2'h0;
      selDone_r <= 1'b0;
      activeIf  <= `IF_MII;
    end
    else if (!selDone_r)
    begin
      settle_r <= settle_r + 2'h1;
      if (settle_r == `SEL_SETTLE)
      begin
        selDone_r <= 1'b1;
        activeIf  <= phy_if_select_pins;
      end
    end
  end
  wire isMii   = selDone_r && (activeIf == `IF_MII || activeIf == `IF_GMII) &&
                 !(activeIf == `IF_GMII && linkSpeed == `SPD_1000);
  wire isGig   = selDone_r && activeIf == `IF_GMII && linkSpeed == `SPD_1000;
  wire isRgmii = selDone_r && activeIf == `IF_RGMII;

  // ==========================================
  // reference divider: stopped in reset, ticks at /2 or /5 from clk, clocks toggle per tick so run at /4 or /10
  reg  [2:0]  refCnt_r;
  reg         refTick_r;
  always @(posedge clk)
  begin
    if (rst)
    begin
      refCnt_r  <= 3'h0;
      refTick_r <= 1'b0;
      gigabit_transmit_clock_out <= 1'b0;
      rgmiiRefClock <= 1'b0;
    end
    else
    begin
      refTick_r <= 1'b0;
      if (refCnt_r >= refDivSetting - 3'h1)
      begin
        refCnt_r  <= 3'h0;
        refTick_r <= 1'b1;
      end
      else
        refCnt_r <= refCnt_r + 3'h1;
      if (refTick_r)
      begin
        gigabit_transmit_clock_out <= isGig ? ~gigabit_transmit_clock_out : 1'b0;
        rgmiiRefClock <= isRgmii ? ~rgmiiRefClock : 1'b0;
      end
    end
  end

  // ==========================================
  // pin synchronisers, three stages, second and third must agree for collision and carrier sense
  reg  [2:0]  txcS_r;
  reg  [2:0]  rxcS_r;
  reg  [2:0]  colS_r;
  reg  [2:0]  crsS_r;
  always @(posedge clk)
  begin
    if (rst)
    begin
      txcS_r <= 3'h0;
      rxcS_r <= 3'h0;
      colS_r <= 3'h0;
      crsS_r <= 3'h0;
      collisionSeen <= 1'b0;
      carrierSeen   <= 1'b0;
    end
    else
    begin
      txcS_r <= {txcS_r[1:0], mii_transmit_clock_in};
      rxcS_r <= {rxcS_r[1:0], mii_receive_clock_in};
      colS_r <= {colS_r[1:0], collision_in};
      crsS_r <= {crsS_r[1:0], carrier_sense_in};
      if (colS_r[1] == colS_r[2])
        collisionSeen <= colS_r[2] & halfDuplex;
      if (crsS_r[1] == crsS_r[2])
        carrierSeen <= crsS_r[2] & halfDuplex;
    end
  end
  wire txRise = txcS_r[1] & ~txcS_r[2];
  wire rxRise = rxcS_r[1] & ~rxcS_r[2];
  wire rxFall = ~rxcS_r[1] & rxcS_r[2];

  // ==========================================
  // transmit: byte in, nibbles or whole bytes out, crc sent on mii only, uninverted on error
  reg  [31:0] crc_r;
  reg  [7:0]  hold_r;
  reg  [3:0]  txPh_r;
  reg         txBusy_r;
  reg         holdLast_r;
  reg         bad_r;
  wire        txStep = isGig ? refTick_r & gigabit_transmit_clock_out :
                       isRgmii ? refTick_r : (isMii ? txRise : 1'b0);
  assign txReady = txStep && (txPh_r == 4'h0) && !txBusy_r;
  function [31:0] crcByte;
    input [31:0] c;
    input [7:0]  d;
    integer i;
    reg [31:0] x;
    begin
      x = c;
      for (i = 0; i < 8; i = i + 1)
        x = (x[0] ^ d[i]) ? ({1'b0, x[31:1]} ^ 32'hEDB8_8320) : {1'b0, x[31:1]};
      crcByte = x;
    end
  endfunction
  wire [31:0] fcs = bad_r ? crc_r : ~crc_r;
  always @(posedge clk)
  begin
    if (rst)
    begin
      crc_r <= 32'hFFFF_FFFF;
      hold_r <= 8'h00;
      txPh_r <= 4'h0;
      txBusy_r <= 1'b0;
      holdLast_r <= 1'b0;
      bad_r <= 1'b0;
      transmit_nibble <= 4'h0;
      transmit_enable_out <= 1'b0;
      gmiiTxData <= 8'h00;
      gmiiTxEnable <= 1'b0;
      rgmiiTxData <= 4'h0;
    end
    else if (txStep)
    begin
      if (txReady && txValid)
      begin
        crc_r <= crcByte(crc_r, txByte);
        bad_r <= bad_r | txUnderflow;
        hold_r <= txByte;
        holdLast_r <= txLast;
      end
      if (!isMii)
      begin
        gmiiTxEnable <= isGig && txValid && txReady;
        gmiiTxData   <= txByte;
        rgmiiTxData  <= isRgmii ? txByte[3:0] : 4'h0;
      end
      else if (txPh_r == 4'h0 && txValid && !txBusy_r)
      begin
        transmit_nibble <= txByte[3:0];
        transmit_enable_out <= 1'b1;
        txPh_r <= 4'h1;
      end
      else if (txPh_r == 4'h1)
      begin
        transmit_nibble <= hold_r[7:4];
        txPh_r <= holdLast_r ? 4'h2 : 4'h0;
      end
      else if (txPh_r >= 4'h2)
      begin
        // eight nibbles of frame check, low first, phases 2 to 9
        transmit_nibble <= fcs[4*(txPh_r-4'h2) +: 4];
        txPh_r <= (txPh_r == 4'h9) ? 4'h0 : txPh_r + 4'h1;
        txBusy_r <= txPh_r != 4'h9;
        if (txPh_r == 4'h9)
        begin
          crc_r <= 32'hFFFF_FFFF;
          bad_r <= 1'b0;
        end
      end
      else
        transmit_enable_out <= 1'b0;
    end
  end

  // ==========================================
  // receive: nibble pairing, error gated by valid
  reg         rxHalf_r;
  reg  [3:0]  rxLow_r;
  always @(posedge clk)
  begin
    if (rst)
    begin
      rxHalf_r <= 1'b0;
      rxLow_r <= 4'h0;
      rxByte <= 8'h00;
      rxByteValid <= 1'b0;
      rxError <= 1'b0;
      rgmiiRxSpeed <= `SPD_10;
    end
    else
    begin
      rxByteValid <= 1'b0;
      if ((isMii || isGig) && rxRise)
      begin
        rxError <= receive_error_in & receive_valid_in;
        if (!receive_valid_in)
          rxHalf_r <= 1'b0;
        else if (!rxHalf_r)
        begin
          rxLow_r <= receive_nibble;
          rxHalf_r <= 1'b1;
        end
        else
        begin
          rxByte <= {receive_nibble, rxLow_r};
          rxByteValid <= 1'b1;
          rxHalf_r <= 1'b0;
        end
      end
      else if (isRgmii && rxRise)
        rxLow_r <= rgmiiRxData;
      else if (isRgmii && rxFall)
      begin
        if (receive_valid_in)
        begin
          rxByte <= {rgmiiRxData, rxLow_r};
          rxByteValid <= 1'b1;
        end
        else
          rgmiiRxSpeed <= rxLow_r[2:1];
      end
    end
  end

  // ==========================================
  // management port
  mgmt_serial u_mgmt
  (
    .clk       (clk),
    .rst       (rst),
    .divider   (management_clock_divider),
    .start     (mgmtStart),
    .isRead    (mgmtRead),
    .phyAddr   (mgmtPhyAddr),
    .regAddr   (mgmtRegAddr),
    .wrData    (mgmtWrData),
    .busy_r    (mgmtBusy),
    .rdData_r  (mgmtRdData),
    .mgmtClk_r (management_clock_out),
    .mdOut_r   (mgmtDataOut),
    .mdOe_r    (mgmtDataOe),
    .mdIn      (mgmtDataIn)
  );
endmodule

// ==== rtl/mac_phy_map.vh ====
// constants for the phy interface and clocking block
`ifndef MAC_PHY_MAP_VH
`define MAC_PHY_MAP_VH
// interface select encodings
`define IF_MII            2'h0
`define IF_RMII           2'h1
`define IF_GMII           2'h2
`define IF_RGMII          2'h3
// speed encodings
`define SPD_10            2'h0
`define SPD_100           2'h1
`define SPD_1000          2'h2
// reference divider settings and reset value
`define REF_DIV_GMII      3'h2
`define REF_DIV_RGMII     3'h5
`define REF_DIV_RESET     3'h2
// management frame layout
`define MG_PRE_BITS       6'h20
`define MG_FRAME_BITS     6'h20
`define MG_DATA_FIRST     6'h10
`define MG_TA_BIT         6'h0E
// default management divider
`define MG_DIV_RESET      8'h28
// cycles counted after reset release before select pins are caught
`define SEL_SETTLE        2'h3
`endif

// ==== rtl/mgmt_serial.v ====
// management serial port: clock divider and frame shifter
`timescale 1ns/100ps
`include "mac_phy_map.vh"
module mgmt_serial
(
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  divider,
  input  wire        start,
  input  wire        isRead,
  input  wire [4:0]  phyAddr,
  input  wire [4:0]  regAddr,
  input  wire [15:0] wrData,
  output reg         busy_r,
  output reg  [15:0] rdData_r,
  output reg         mgmtClk_r,
  output reg         mdOut_r,
  output reg         mdOe_r,
  input  wire        mdIn
);
  // ==========================================
  // divider: one tick per half period
  reg  [7:0]  divCnt_r;
  wire        halfTick = (divCnt_r == 8'h00);
  always @(posedge clk)
  begin
    if (rst || !busy_r)
      divCnt_r <= divider;
    else if (halfTick)
      divCnt_r <= divider;
    else
      divCnt_r <= divCnt_r - 8'h01;
  end

  // ==========================================
  // frame shifter
  reg         inPre_r;
  reg  [5:0]  bitCnt_r;
  reg  [31:0] shift_r;
  reg         readOp_r;
  reg  [2:0]  s1_r;
  reg  [2:0]  s2_r;
  reg         mdInSync;
  always @(posedge clk)
  begin
    if (rst)
    begin
      s1_r <= 3'h0;
    end
    else
    begin
      s1_r <= {s1_r[1:0], mdIn};
    end
  end
  always @*
  begin
    mdInSync = s1_r[2];
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      busy_r    <= 1'b0;
      mgmtClk_r <= 1'b0;
      mdOut_r   <= 1'b1;
      mdOe_r    <= 1'b0;
      inPre_r   <= 1'b0;
      bitCnt_r  <= 6'h00;
      shift_r   <= 32'h0000_0000;
      readOp_r  <= 1'b0;
      rdData_r  <= 16'h0000;
    end
    else if (!busy_r)
    begin
      mgmtClk_r <= 1'b0;
      mdOe_r    <= 1'b0;
      if (start)
      begin
        busy_r   <= 1'b1;
        inPre_r  <= 1'b1;
        bitCnt_r <= `MG_PRE_BITS - 6'h01;
        readOp_r <= isRead;
        shift_r  <= {2'b01, isRead ? 2'b10 : 2'b01, phyAddr, regAddr, 2'b10, wrData};
        mdOe_r   <= 1'b1;
        mdOut_r  <= 1'b1;
      end
    end
    else if (halfTick)
    begin
      mgmtClk_r <= ~mgmtClk_r;
      if (mgmtClk_r)
      begin
        // falling edge: take the read bit settled over a whole period, then present the next
        if (!inPre_r && readOp_r && bitCnt_r < `MG_DATA_FIRST)
          rdData_r <= {rdData_r[14:0], mdInSync};
        if (bitCnt_r == 6'h00)
        begin
          if (inPre_r)
          begin
            inPre_r  <= 1'b0;
            bitCnt_r <= `MG_FRAME_BITS - 6'h01;
            mdOut_r  <= shift_r[31];
            shift_r  <= {shift_r[30:0], 1'b0};
          end
          else
          begin
            busy_r <= 1'b0;
            mdOe_r <= 1'b0;
          end
        end
        else
        begin
          bitCnt_r <= bitCnt_r - 6'h01;
          if (!inPre_r)
          begin
            mdOut_r <= shift_r[31];
            shift_r <= {shift_r[30:0], 1'b0};
            // release the pin for the read data bits only, turnaround stays driven
            mdOe_r  <= !(readOp_r && bitCnt_r <= `MG_TA_BIT + 6'h02);
          end
        end
      end
    end
  end
endmodule

// ==== testbench/mac_phy_interface_clocking_assertions.sv ====
// assertion checker for the phy interface and clocking block
`timescale 1ns/100ps
`include "mac_phy_map.vh"
module mac_phy_interface_clocking_assertions
(
  input wire       clk,
  input wire       rst,
  input wire       halfDuplex,
  input wire [2:0] refDivSetting,
  input wire       transmit_enable_out,
  input wire       gmiiTxEnable,
  input wire       gigabit_transmit_clock_out,
  input wire       rgmiiRefClock,
  input wire       collision_in,
  input wire       collisionSeen,
  input wire       carrierSeen,
  input wire [1:0] activeIf,
  input wire [7:0] management_clock_divider,
  input wire       mgmtBusy,
  input wire       management_clock_out,
  input wire       mgmtDataOe
);
  // ====
  // cycles since reset, saturating
  reg  [3:0] sinceRst_r;
  wire [3:0] sinceRst_nxt = (sinceRst_r == 4'hF) ? sinceRst_r : sinceRst_r + 4'h1;
  always @(posedge clk)
    sinceRst_r <= rst ? 4'h0 : sinceRst_nxt;
  // cycles since the management clock last changed
  reg        mdcPrev_r;
  reg  [7:0] mdcRun_r;
  always @(posedge clk)
  begin
    mdcPrev_r <= management_clock_out;
    mdcRun_r  <= (rst || management_clock_out != mdcPrev_r) ? 8'h00 : mdcRun_r + 8'h01;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_fullDup;
    !halfDuplex [*4];
  endsequence
  // ====
  // properties
  property p_selHeld;
    sinceRst_r > 4'h6 |-> $stable(activeIf);
  endproperty
  a_selHeld: assert property (p_selHeld) else $error("select moved");
  property p_colQuiet;
    s_fullDup |-> !collisionSeen;
  endproperty
  a_colQuiet: assert property (p_colQuiet) else $error("collision in full duplex");
  property p_crsQuiet;
    s_fullDup |-> !carrierSeen;
  endproperty
  a_crsQuiet: assert property (p_crsQuiet) else $error("carrier in full duplex");
  property p_colSync;
    $rose(collisionSeen) |-> $past(collision_in, 2);
  endproperty
  a_colSync: assert property (p_colSync) else $error("collision too early");
  property p_refStop;
    disable iff (1'b0) rst |=> !rgmiiRefClock && !gigabit_transmit_clock_out;
  endproperty
  a_refStop: assert property (p_refStop) else $error("clock runs in reset");
  property p_oneIf;
    (transmit_enable_out |-> activeIf == `IF_MII || activeIf == `IF_GMII) and
    (gmiiTxEnable |-> activeIf == `IF_GMII);
  endproperty
  a_oneIf: assert property (p_oneIf) else $error("wrong interface active");
  property p_miiNoGig;
    activeIf == `IF_MII && sinceRst_r > 4'h6 |-> !gmiiTxEnable && $stable(gigabit_transmit_clock_out);
  endproperty
  a_miiNoGig: assert property (p_miiNoGig) else $error("gigabit on mii");
  property p_refRun;
    activeIf == `IF_RGMII && refDivSetting == `REF_DIV_RGMII |-> ##[1:12] $changed(rgmiiRefClock);
  endproperty
  a_refRun: assert property (p_refRun) else $error("reference clock idle");
  property p_mdcHalf;
    $fell(management_clock_out) |-> mdcRun_r == management_clock_divider;
  endproperty
  a_mdcHalf: assert property (p_mdcHalf) else $error("management clock rate");
  property p_frameDrive;
    $rose(mgmtBusy) |-> ##[0:2] mgmtDataOe;
  endproperty
  a_frameDrive: assert property (p_frameDrive) else $error("frame not driven");
endmodule
bind mac_phy_interface_clocking mac_phy_interface_clocking_assertions checker_inst (.*);

// ==== testbench/phy_model.sv ====
// behavioural phy: mii clocks, receive stream, line status, mdio responder
`timescale 1ns/100ps
module phy_model
#(
  parameter [15:0] RD_VAL = 16'h0000
)
(
  input  wire        clk,
  input  wire        rxGo,
  input  wire [15:0] rxWord,
  input  wire [1:0]  rxErr,
  input  wire        colReq,
  input  wire        management_clock_out,
  input  wire        mgmtDataOe,
  input  wire        mgmtDataOut,
  output reg         mii_transmit_clock_in,
  output reg         mii_receive_clock_in,
  output reg  [3:0]  receive_nibble,
  output reg         receive_valid_in,
  output reg         receive_error_in,
  output reg         collision_in,
  output reg         carrier_sense_in,
  output wire        mgmtDataIn
);
  reg  [3:0] div;
  reg  [2:0] step;
  reg  [4:0] mdCnt;
  reg        mdcOld;
  reg        phyBit;
  wire       fall = (div[2:0] == 3'h7) && mii_receive_clock_in;
  initial
  begin
    {div, step, mdCnt, mdcOld, phyBit, receive_nibble} = '0;
    {mii_transmit_clock_in, mii_receive_clock_in, receive_valid_in} = '0;
    {receive_error_in, collision_in, carrier_sense_in} = '0;
  end
  // pulled up unless the mac drives or the phy has its turn
  assign mgmtDataIn = mgmtDataOe ? mgmtDataOut : (mdCnt != 5'h0 ? phyBit : 1'b1);
  always @(posedge clk)
  begin
    div <= div + 4'h1;
    mdcOld <= management_clock_out;
    collision_in <= colReq;
    carrier_sense_in <= colReq | receive_valid_in;
    if (div[2:0] == 3'h7)
    begin
      mii_transmit_clock_in <= ~mii_transmit_clock_in;
      mii_receive_clock_in <= ~mii_receive_clock_in;
    end
    if (rxGo && step == 3'h0)
      step <= 3'h1;
    else if (fall && step != 3'h0)
    begin
      step <= (step == 3'h6) ? 3'h0 : step + 3'h1;
      receive_valid_in <= step < 3'h5;
      receive_error_in <= (step == 3'h4) ? rxErr[0] : (step == 3'h5) & rxErr[1];
      receive_nibble <= (step < 3'h5) ? rxWord[4*step-4 +: 4] : ~receive_nibble;
    end
    else if (fall)
      receive_nibble <= ~receive_nibble;
    if (mdcOld && !management_clock_out)
    begin
      mdCnt <= mgmtDataOe ? 5'h0 : mdCnt + 5'h1;
      // read data msb first from the first released bit, pulled high after
      phyBit <= (mdCnt < 5'h10) ? RD_VAL[4'hF - mdCnt[3:0]] : 1'b1;
    end
  end
endmodule

// ==== testbench/mac_phy_interface_clocking_bench.sv ====
// self-checking bench for the phy interface and clocking block
`timescale 1ns/100ps
`include "mac_phy_map.vh"
module mac_phy_interface_clocking_bench;
  localparam [15:0] RD_VAL = 16'hA5C3;
  reg clk, rst, halfDuplex, txValid, txLast, txUnderflow, mgmtStart, mgmtRead, rxGo, colReq;
  reg rxErrSeen;
  reg  [1:0]  phy_if_select_pins, linkSpeed, rxErr;
  reg  [2:0]  refDivSetting;
  reg  [7:0]  txByte, management_clock_divider;
  reg  [4:0]  mgmtPhyAddr, mgmtRegAddr;
  reg  [15:0] mgmtWrData, rxWord;
  reg  [63:0] mdBits;
  reg  [3:0]  nibQ[$];
  reg  [3:0]  expQ[$];
  reg  [7:0]  rxQ[$];
  integer     n_fail, cmp_count, i, k;
  wire txReady, transmit_enable_out, gigabit_transmit_clock_out, rgmiiRefClock, gmiiTxEnable;
  wire rxByteValid, rxError, collisionSeen, carrierSeen, mgmtBusy, mgmtDataIn;
  wire management_clock_out, mgmtDataOut, mgmtDataOe, receive_valid_in, receive_error_in;
  wire mii_transmit_clock_in, mii_receive_clock_in, collision_in, carrier_sense_in;
  wire [3:0]  transmit_nibble, receive_nibble;
  wire [7:0]  rxByte;
  wire [1:0]  activeIf;
  wire [15:0] mgmtRdData;
  mac_phy_interface_clocking mac_phy_interface_clocking_inst
  (
    .*, .gmiiTxData(), .rgmiiTxData(), .rgmiiRxSpeed(), .rgmiiRxData(4'h0)
  );
  phy_model #(.RD_VAL(RD_VAL)) phy_model_inst (.*);
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ====
  // monitors
  always @(posedge mii_transmit_clock_in)
    if (transmit_enable_out)
      nibQ.push_back(transmit_nibble);
  always @(posedge clk)
  begin
    if (rxByteValid)
      rxQ.push_back(rxByte);
    if (rxError)
      rxErrSeen = 1'b1;
  end
  always @(posedge management_clock_out)
    if (mgmtDataOe)
      mdBits = {mdBits[62:0], mgmtDataOut};
  // ====
  // tasks
  task check(input [63:0] seen, input [63:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task give_verdict;
  begin
    if (n_fail == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  task bail;
  begin
    n_fail = n_fail + 1;
    give_verdict;
  end
  endtask
  function [31:0] crcAdd(input [31:0] c, input [7:0] b);
    integer j;
  begin
    crcAdd = c ^ {24'h0, b};
    for (j = 0; j < 8; j = j + 1)
      crcAdd = crcAdd[0] ? (crcAdd >> 1) ^ 32'hEDB8_8320 : crcAdd >> 1;
  end
  endfunction
  task doReset(input [1:0] sel);
  begin
    @(negedge clk);
    rst = 1'b1;
    phy_if_select_pins = sel;
    refDivSetting = (sel == `IF_RGMII) ? `REF_DIV_RGMII : `REF_DIV_GMII;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
  end
  endtask
  task sendFrame(input integer len, input bad);
    reg [31:0] crc;
    integer j;
  begin
    crc = 32'hFFFF_FFFF;
    nibQ.delete();
    expQ.delete();
    for (j = 0; j < len; j = j + 1)
    begin
      txByte = $urandom;
      txValid = 1'b1;
      txLast = (j == len - 1);
      txUnderflow = bad && (j == 1);
      crc = crcAdd(crc, txByte);
      expQ.push_back(txByte[3:0]);
      expQ.push_back(txByte[7:4]);
      for (k = 0; k < 100 && txReady !== 1'b1; k = k + 1)
        @(negedge clk);
      if (k == 100)
        bail;
      @(negedge clk);
    end
    txValid = 1'b0;
    txLast = 1'b0;
    txUnderflow = 1'b0;
    for (j = 0; j < 8; j = j + 1)
      expQ.push_back(bad ? crc[4*j +: 4] : ~crc[4*j +: 4]);
    for (k = 0; k < 2000 && nibQ.size() < expQ.size(); k = k + 1)
      @(negedge clk);
    repeat (40) @(negedge clk);
    check(nibQ.size(), expQ.size());
    for (j = 0; j < expQ.size(); j = j + 1)
      check(nibQ[j], expQ[j]);
  end
  endtask
  task recv(input [1:0] err);
  begin
    rxQ.delete();
    rxErrSeen = 1'b0;
    rxWord = $urandom;
    rxErr = err;
    rxGo = 1'b1;
    @(negedge clk);
    rxGo = 1'b0;
    repeat (150) @(negedge clk);
    check(rxQ.size(), 2);
    check({rxQ[1], rxQ[0]}, rxWord);
    check(rxErrSeen, err[0]);
  end
  endtask
  task mgmtOp(input rd);
  begin
    @(negedge clk);
    mgmtStart = 1'b1;
    mgmtRead = rd;
    mgmtPhyAddr = $urandom;
    mgmtRegAddr = $urandom;
    mgmtWrData = $urandom;
    @(negedge clk);
    mgmtStart = 1'b0;
    @(negedge clk);
    for (k = 0; k < 8000 && mgmtBusy === 1'b1; k = k + 1)
      @(negedge clk);
    if (k == 8000)
      bail;
  end
  endtask
  // ====
  // main sequence
  initial
  begin
    rst = 1'b1;
    {halfDuplex, txValid, txLast, txUnderflow, mgmtStart, mgmtRead, rxGo, colReq} = '0;
    {linkSpeed, rxErr, txByte, mgmtPhyAddr, mgmtRegAddr, mgmtWrData, rxWord, mdBits} = '0;
    phy_if_select_pins = `IF_MII;
    refDivSetting = `REF_DIV_RESET;
    management_clock_divider = `MG_DIV_RESET;
    n_fail = 0;
    cmp_count = 0;
    rxErrSeen = 1'b0;
    i = $urandom(32'ha46f_7ea1);
    for (i = 0; i < 4; i = i + 1)
    begin
      doReset(i[1:0]);
      phy_if_select_pins = ~phy_if_select_pins;
      repeat (30) @(negedge clk);
      check(activeIf, i[1:0]);
    end
    linkSpeed = `SPD_100;
    doReset(`IF_MII);
    sendFrame(1, 1'b0);
    sendFrame(2 + $urandom % 10, 1'b1);
    sendFrame(2 + $urandom % 10, 1'b0);
    recv(2'h0);
    recv(2'h2);
    recv(2'h1);
    colReq = 1'b1;
    halfDuplex = 1'b1;
    repeat (8) @(negedge clk);
    check({collisionSeen, carrierSeen}, 2'h3);
    halfDuplex = 1'b0;
    repeat (8) @(negedge clk);
    check({collisionSeen, carrierSeen}, 2'h0);
    colReq = 1'b0;
    mgmtOp(1'b0);
    check(mdBits, {32'hFFFF_FFFF, 4'h5, mgmtPhyAddr, mgmtRegAddr, 2'h2, mgmtWrData});
    mgmtOp(1'b1);
    check(mdBits[47:0], {32'hFFFF_FFFF, 4'h6, mgmtPhyAddr, mgmtRegAddr, 2'h2});
    check(mgmtRdData, RD_VAL);
    give_verdict;
  end
endmodule
